// ===== rxes_pkg.sv
// constants and types shared by the receive elastic store and signaling extractor
// Contract
// - two-frame circular store, separate write/read pointers
// - store full: slip at frame boundary, delete frame
// - store empty: slip at frame boundary, repeat frame
// - line-timed backplane: store may be bypassed
// - bypass: compare external rate tick, count slips
// - superframe position travels with stored frames
// - idle code replaces all channels while out of frame
// - idle code resets to all ones
// - extract E1, SF, ESF, loop-carrier signaling, channel aligned
// - signaling repeated for the whole superframe
// - ESF/E1: ABCD in output bits one to four, upper four bits zero
// - SF and loop-carrier: ABAB pattern per channel
// - three superframes of signaling storage, frozen after a slip, not on oof
// - debounce: new state needs two equal superframes
// - slip freezes signaling for that superframe
// - per-timeslot fixing, inversion and debounce controls
// - per-channel signaling change indication with channel
package rxes_pkg;
	typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_SLC, FMT_E1} rxes_fmt_e;
	localparam int NCH = 32;
	localparam int TS_W = 5;
	localparam int LVL_W = 7;
	localparam logic [5:0] T1_FLEN = 6'h18;
	localparam logic [5:0] E1_FLEN = 6'h20;
	localparam logic [4:0] T1_FNUM_FIRST = 5'h01;
	localparam logic [4:0] E1_FNUM_FIRST = 5'h00;
	localparam logic [4:0] FR_SIG_A = 5'h06;
	localparam logic [4:0] FR_SIG_B = 5'h0c;
	localparam logic [4:0] FR_SIG_C = 5'h12;
	localparam logic [4:0] FR_SIG_D = 5'h18;
	localparam logic [4:0] E1_SIG_TS = 5'h10;
	localparam logic [4:0] E1_SIG_HALF = 5'h10;
	localparam logic [7:0] IDLE_RST = 8'hff;
	localparam logic [LVL_W-1:0] LVL_RST = 7'h00;
	localparam logic [3:0] SIG_UPPER = 4'h0;
endpackage

// ===== rxes_top.sv
// receive elastic store with signaling extraction toward the backplane
`timescale 1ns/1ps
module rxes_top #(
	parameter int SLIP_CW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire rxes_pkg::rxes_fmt_e fmt,
	input wire logic bypass,
	input wire logic idle_en,
	input wire logic oof,
	input wire logic idle_code_wr,
	input wire logic [7:0] idle_code_in,
	input wire logic [31:0] dbnc_en,
	input wire logic [31:0] fix_en,
	input wire logic [3:0] fix_val,
	input wire logic [31:0] inv_en,
	input wire logic in_valid,
	output logic in_ready_q,
	input wire logic [7:0] in_byte,
	input wire logic [4:0] in_ts,
	input wire logic [4:0] in_fnum,
	input wire logic ext_tick,
	input wire logic out_ready,
	output logic out_valid_q,
	output logic [7:0] out_pcm_q,
	output logic [7:0] out_sig_q,
	output logic [4:0] out_ts_q,
	output logic slip_q,
	output logic slip_del_q,
	output logic [4:0] slip_fnum_q,
	output logic [SLIP_CW-1:0] slip_count_q,
	output logic sig_chg_q,
	output logic [4:0] sig_chg_ch_q
);
	if (SLIP_CW < 4)
	begin : g_bad_cw
		$error("slip counter too narrow");
	end

	function automatic logic [5:0] first_set(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 31; i >= 0; i--)
			if (v[i])
				r = {1'b1, 5'(i)};
		return r;
	endfunction

	logic [7:0] mem_q [2*rxes_pkg::NCH];
	logic [4:0] tag_q [2];
	logic [7:0] idle_code_q;
	logic wr_slot_q, rd_slot_q, full_seen_q, empty_seen_q;
	logic [4:0] rd_ts_q;
	logic [rxes_pkg::LVL_W-1:0] lvl_q, lvl_d;
	logic tick_s1_q, tick_s2_q, tick_s3_q;
	logic [1:0] cnt_q, cnt_d;
	logic [7:0] e1_pcm_q, e1_sig_q;
	logic [4:0] e1_ts_q;
	logic slip_in_sf_q;
	logic [31:0] chg_pend_q;
	logic [3:0] sig_out [rxes_pkg::NCH];
	wire logic [31:0] chg_set;

	wire e1_mode = fmt == rxes_pkg::FMT_E1;
	wire dup_ab = fmt == rxes_pkg::FMT_SF || fmt == rxes_pkg::FMT_SLC;
	wire [5:0] flen = e1_mode ? rxes_pkg::E1_FLEN : rxes_pkg::T1_FLEN;
	wire [4:0] last_ts = 5'(flen - 6'h01);
	wire [4:0] sf_first = e1_mode ? rxes_pkg::E1_FNUM_FIRST : rxes_pkg::T1_FNUM_FIRST;
	wire wr_fire = in_valid && in_ready_q;
	wire store_wr = wr_fire && !bypass;
	wire [7:0] wr_data = (idle_en && oof) ? idle_code_q : in_byte;
	wire [5:0] wr_addr = {wr_slot_q, in_ts};
	wire [5:0] rd_addr = {rd_slot_q, rd_ts_q};
	wire tick_rise = tick_s2_q && !tick_s3_q;
	wire pop = out_valid_q && out_ready;
	wire push_ok = cnt_q != 2'h2 || pop;
	wire push = bypass ? wr_fire : push_ok;
	wire rd_adv = bypass ? tick_rise : push;
	wire rd_last = rd_adv && rd_ts_q == last_ts;
	wire slip_del = rd_last && full_seen_q;
	wire slip_rep = rd_last && empty_seen_q && !full_seen_q;
	wire [7:0] rd_byte = bypass ? wr_data : mem_q[rd_addr];
	wire [4:0] rd_ts = bypass ? in_ts : rd_ts_q;
	wire [4:0] rd_fnum = bypass ? in_fnum : tag_q[rd_slot_q];
	wire sf_bnd = push && rd_ts == 5'h00 && rd_fnum == sf_first;
	wire [3:0] sig_sel = fix_en[rd_ts] ? fix_val : sig_out[rd_ts];
	wire [3:0] sig_nib = dup_ab ? {sig_sel[3:2], sig_sel[3:2]} : sig_sel;
	wire [7:0] push_sig = {rxes_pkg::SIG_UPPER, sig_nib};
	wire [7:0] push_pcm = inv_en[rd_ts] ? ~rd_byte : rd_byte;
	wire [5:0] chg_pick = first_set(chg_pend_q);

	always_comb
	begin
		int l;
		l = int'(lvl_q) + (store_wr ? 1 : 0) - (rd_adv ? 1 : 0);
		if (bypass)
			l = int'(lvl_q) + (wr_fire ? 1 : 0) - (rd_adv ? 1 : 0);
		if (slip_rep)
			l = l + int'(flen);
		if (slip_del)
			l = l - int'(flen);
		if (l < 0)
			l = 0;
		if (l > 2 * int'(flen))
			l = 2 * int'(flen);
		lvl_d = rxes_pkg::LVL_W'(l);
	end

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (store_wr)
			mem_q[wr_addr] <= wr_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
			idle_code_q <= rxes_pkg::IDLE_RST;
			wr_slot_q <= 1'b0;
			tag_q[0] <= 5'h00;
			tag_q[1] <= 5'h00;
		end
		else
		begin
			tick_s1_q <= ext_tick;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
			if (idle_code_wr)
				idle_code_q <= idle_code_in;
			if (store_wr && in_ts == 5'h00)
				tag_q[wr_slot_q] <= in_fnum;
			if (store_wr && in_ts == last_ts)
				wr_slot_q <= !wr_slot_q;
		end
	end

	// full and empty are remembered until the read side reaches a frame edge,
	// so a slip never cuts a frame in half
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_slot_q <= 1'b0;
			rd_ts_q <= 5'h00;
			lvl_q <= rxes_pkg::LVL_RST;
			full_seen_q <= 1'b0;
			empty_seen_q <= 1'b0;
			slip_q <= 1'b0;
			slip_del_q <= 1'b0;
			slip_fnum_q <= 5'h00;
			slip_count_q <= '0;
		end
		else
		begin
			lvl_q <= lvl_d;
			if (rd_adv)
				rd_ts_q <= rd_last ? 5'h00 : rd_ts_q + 5'h01;
			if (rd_last && !slip_del && !slip_rep)
				rd_slot_q <= !rd_slot_q;
			full_seen_q <= (full_seen_q && !rd_last) || (wr_fire && lvl_q == 7'(2 * flen));
			empty_seen_q <= (empty_seen_q && !rd_last) || (rd_adv && lvl_q == rxes_pkg::LVL_RST);
			slip_q <= slip_del || slip_rep;
			slip_del_q <= slip_del;
			if (slip_del || slip_rep)
			begin
				slip_fnum_q <= rd_fnum;
				slip_count_q <= slip_count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 2'h0;
			out_valid_q <= 1'b0;
			in_ready_q <= 1'b0;
			e1_pcm_q <= 8'h00;
			e1_sig_q <= 8'h00;
			e1_ts_q <= 5'h00;
			out_pcm_q <= 8'h00;
			out_sig_q <= 8'h00;
			out_ts_q <= 5'h00;
		end
		else
		begin
			cnt_q <= cnt_d;
			out_valid_q <= cnt_d != 2'h0;
			in_ready_q <= !bypass || cnt_d == 2'h0;
			if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2 && pop)))
			begin
				e1_pcm_q <= push_pcm;
				e1_sig_q <= push_sig;
				e1_ts_q <= rd_ts;
			end
			if (push && (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)))
			begin
				out_pcm_q <= push_pcm;
				out_sig_q <= push_sig;
				out_ts_q <= rd_ts;
			end
			else if (pop && cnt_q == 2'h2)
			begin
				out_pcm_q <= e1_pcm_q;
				out_sig_q <= e1_sig_q;
				out_ts_q <= e1_ts_q;
			end
		end
	end

	genvar c;
	generate
		for (c = 0; c < rxes_pkg::NCH; c++)
		begin : g_ch
			logic [3:0] col_q, prev_q, out_q;
			wire t1_hit = !e1_mode && push && rd_ts == 5'(c);
			wire e1_hi = e1_mode && push && rd_ts == rxes_pkg::E1_SIG_TS && c > 0 && c < 16 && rd_fnum == 5'(c);
			wire e1_lo = e1_mode && push && rd_ts == rxes_pkg::E1_SIG_TS && c > 16
				&& rd_fnum == 5'(c) - rxes_pkg::E1_SIG_HALF;
			wire steady = col_q == prev_q;
			wire [3:0] nxt = (dbnc_en[c] && !steady) ? out_q : col_q;
			wire upd = sf_bnd && !slip_in_sf_q;
			assign sig_out[c] = out_q;
			assign chg_set[c] = upd && nxt != out_q;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					col_q <= 4'h0;
					prev_q <= 4'h0;
					out_q <= 4'h0;
				end
				else
				begin
					if (t1_hit && rd_fnum == rxes_pkg::FR_SIG_A)
						col_q[3] <= rd_byte[0];
					if (t1_hit && rd_fnum == rxes_pkg::FR_SIG_B)
						col_q[2] <= rd_byte[0];
					if (t1_hit && rd_fnum == rxes_pkg::FR_SIG_C)
						col_q[1] <= rd_byte[0];
					if (t1_hit && rd_fnum == rxes_pkg::FR_SIG_D)
						col_q[0] <= rd_byte[0];
					if (e1_hi)
						col_q <= rd_byte[7:4];
					if (e1_lo)
						col_q <= rd_byte[3:0];
					if (sf_bnd)
						prev_q <= col_q;
					if (upd)
						out_q <= nxt;
				end
			end
		end
	endgenerate

	// a new change wins over the clear of the one being reported
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slip_in_sf_q <= 1'b0;
			chg_pend_q <= 32'h0;
			sig_chg_q <= 1'b0;
			sig_chg_ch_q <= 5'h00;
		end
		else
		begin
			slip_in_sf_q <= slip_q || (slip_in_sf_q && !sf_bnd);
			sig_chg_q <= chg_pick[5];
			sig_chg_ch_q <= chg_pick[4:0];
			chg_pend_q <= (chg_pend_q & ~(chg_pick[5] ? (32'h1 << chg_pick[4:0]) : 32'h0)) | chg_set;
		end
	end

	logic idle_wr_seen_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			idle_wr_seen_q <= 1'b0;
		else if (idle_code_wr)
			idle_wr_seen_q <= 1'b1;
	end

	chk_idle_reset: assert property (@(posedge clk) disable iff (!rst_n)
		!idle_wr_seen_q |-> idle_code_q == rxes_pkg::IDLE_RST) else $error("idle code not all ones");
	chk_idle_subst: assert property (@(posedge clk) disable iff (!rst_n)
		store_wr && idle_en && oof && !idle_code_wr |=> mem_q[$past(wr_addr)] == idle_code_q)
		else $error("idle code not stored");
	chk_slip_delete: assert property (@(posedge clk) disable iff (!rst_n)
		slip_del |=> slip_q && slip_del_q && rd_slot_q == $past(rd_slot_q)) else $error("delete slip wrong");
	chk_slip_repeat: assert property (@(posedge clk) disable iff (!rst_n)
		rd_last && empty_seen_q && !full_seen_q |=> slip_q && !slip_del_q) else $error("repeat slip wrong");
	chk_slip_count: assert property (@(posedge clk) disable iff (!rst_n)
		slip_q |-> slip_count_q == $past(slip_count_q) + 1'b1) else $error("slip not counted");
	chk_store_ready: assert property (@(posedge clk) disable iff (!rst_n)
		!bypass && $past(!bypass) && $past(rst_n) |-> in_ready_q) else $error("store refused line data");
	chk_freeze_sf: assert property (@(posedge clk) disable iff (!rst_n)
		sf_bnd && slip_in_sf_q |=> g_ch[1].out_q == $past(g_ch[1].out_q)) else $error("signaling not frozen");
	chk_debounce_hold: assert property (@(posedge clk) disable iff (!rst_n)
		sf_bnd && dbnc_en[1] && g_ch[1].col_q != g_ch[1].prev_q |=> $stable(g_ch[1].out_q))
		else $error("debounce let change through");
	chk_sig_upper: assert property (@(posedge clk) disable iff (!rst_n)
		out_valid_q |-> out_sig_q[7:4] == rxes_pkg::SIG_UPPER) else $error("signaling bits misplaced");
	chk_chg_report: assert property (@(posedge clk) disable iff (!rst_n)
		chg_set != 32'h0 |-> ##[1:40] sig_chg_q) else $error("change not reported");

	cov_slip_delete: cover property (@(posedge clk) disable iff (!rst_n) slip_q && slip_del_q);
	cov_slip_repeat: cover property (@(posedge clk) disable iff (!rst_n) slip_q && !slip_del_q);
	cov_sig_change: cover property (@(posedge clk) disable iff (!rst_n) sig_chg_q);
	cov_stall_full: cover property (@(posedge clk) disable iff (!rst_n) cnt_q == 2'h2 && !out_ready);
endmodule

// ===== rxes_sink.sv
// downstream backplane logic that pulls pcm and signaling at a chosen pace
`timescale 1ns/1ps
module rxes_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] pace,
	output logic out_ready
);
	logic tog_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tog_q <= 1'b0;
		else
			tog_q <= ~tog_q;
	end
	// pace 0 always ready, 1 every other cycle (slower than the line), 2 stalled
	assign out_ready = (pace == 2'h0) | ((pace == 2'h1) & tog_q);
endmodule

// ===== rx_elastic_store_signaling_extract_test.sv
// self-checking bench for the receive elastic store and signaling extractor
`timescale 1ns/1ps
module rx_elastic_store_signaling_extract_test;
	typedef struct packed
	{
		logic wr;
		logic [7:0] code;
		logic [31:0] inv;
		logic [7:0] exp;
	} rxes_row_s;
	rxes_row_s rows [4] = '{'{1'b0, 8'h00, 32'h0, 8'hff}, '{1'b1, 8'h5a, 32'h0, 8'h5a},
		'{1'b1, 8'h5a, 32'hffff_ffff, 8'ha5}, '{1'b1, 8'h00, 32'hffff_ffff, 8'hff}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bypass = 1'b0;
	logic idle_en = 1'b1;
	logic oof = 1'b1;
	logic idle_code_wr = 1'b0;
	logic [7:0] idle_code_in = 8'h00;
	logic [31:0] inv_en = 32'h0;
	logic in_valid = 1'b0;
	logic [7:0] in_byte = 8'h00;
	logic [4:0] in_ts = 5'h00;
	logic [4:0] in_fnum = 5'h01;
	logic ext_tick = 1'b0;
	logic [1:0] pace = 2'h0;
	logic sig_on = 1'b0;
	logic in_ready_q, out_ready, out_valid_q, slip_q, slip_del_q, sig_chg_q;
	logic [7:0] out_pcm_q, out_sig_q;
	logic [4:0] out_ts_q, slip_fnum_q, sig_chg_ch_q;
	logic [15:0] slip_count_q, slip_hold;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n_rep = 0;
	int n_del = 0;
	int sf = 0;
	logic chg3 = 1'b0;
	logic [31:0] dbnc_en = 32'h0000_0002;
	rxes_pkg::rxes_fmt_e fmt = rxes_pkg::FMT_SF;
	wire logic pop = out_valid_q & out_ready;
	// channel 3 carries A (and D in esf), channel 7 is fixed, channel 1 is debounced
	wire logic [7:0] sig_exp = (out_ts_q == 5'h03) ? ((fmt == rxes_pkg::FMT_ESF) ? 8'h09 : 8'h0a)
		: (out_ts_q == 5'h07) ? 8'h05 : (out_ts_q == 5'h01 && sf >= 4) ? 8'h0a : 8'h00;

	rxes_top dut (.clk(clk), .rst_n(rst_n), .fmt(fmt), .bypass(bypass), .idle_en(idle_en),
		.oof(oof), .idle_code_wr(idle_code_wr), .idle_code_in(idle_code_in), .dbnc_en(dbnc_en),
		.fix_en(32'h0000_0080), .fix_val(4'h5), .inv_en(inv_en), .in_valid(in_valid),
		.in_ready_q(in_ready_q), .in_byte(in_byte), .in_ts(in_ts), .in_fnum(in_fnum),
		.ext_tick(ext_tick), .out_ready(out_ready), .out_valid_q(out_valid_q), .out_pcm_q(out_pcm_q),
		.out_sig_q(out_sig_q), .out_ts_q(out_ts_q), .slip_q(slip_q), .slip_del_q(slip_del_q),
		.slip_fnum_q(slip_fnum_q), .slip_count_q(slip_count_q), .sig_chg_q(sig_chg_q),
		.sig_chg_ch_q(sig_chg_ch_q));
	rxes_sink sink (.clk(clk), .rst_n(rst_n), .pace(pace), .out_ready(out_ready));

	always #20 clk = ~clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic stop_test;
	begin
		$display("checked %0d samples, %0d errors", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	// a refused byte stays on the inputs until the edge that takes it
	task automatic send_frame(input logic [4:0] fn);
	begin
		for (int t = 0; t < 24; t++)
		begin
			@(negedge clk);
			while (in_ready_q !== 1'b1)
				@(negedge clk);
			@(posedge clk);
			in_valid <= 1'b1;
			in_ts <= t[4:0];
			in_fnum <= fn;
			in_byte <= ((t == 3 && (fn == 5'h06 || fn == 5'h18)) || (t == 1 && fn == 5'h06 && sf >= 2))
				? 8'h01 : 8'h00;
		end
		@(negedge clk);
		while (in_ready_q !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		in_valid <= 1'b0;
	end
	endtask

	task automatic chk_pops(input logic [7:0] exp);
	begin
		// the first entries may still hold words read before the change
		repeat (4) @(posedge clk);
		repeat (24)
		begin
			@(negedge clk);
			chk({7'h00, out_valid_q, out_pcm_q}, {8'h01, exp});
		end
		@(posedge clk);
	end
	endtask

	// bypass run of whole superframes, signaling compared in the one or two chosen ones
	task automatic run_sf(input int nsf, input int nfr, input int chk_a, input int chk_b);
	begin
		for (sf = 0; sf < nsf; sf++)
		begin
			sig_on <= (sf == chk_a || sf == chk_b);
			for (int f = 1; f <= nfr; f++)
				send_frame(f[4:0]);
		end
		sig_on <= 1'b0;
	end
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		ext_tick <= in_valid & in_ready_q;
		if (slip_q)
		begin
			n_rep <= n_rep + int'(!slip_del_q);
			n_del <= n_del + int'(slip_del_q);
		end
		if (!rst_n)
			chg3 <= 1'b0;
		else if (sig_chg_q && sig_chg_ch_q == 5'h03)
			chg3 <= 1'b1;
		if (pop && sig_on)
			chk({8'h00, out_sig_q}, {8'h00, sig_exp});
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk);
		chk({in_ready_q, out_valid_q, slip_q, sig_chg_q, 12'h000}, 16'h0000);
		chk(slip_count_q, 16'h0000);
		$display("reset test done");
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		foreach (rows[i])
		begin
			idle_code_in <= rows[i].code;
			idle_code_wr <= rows[i].wr;
			inv_en <= rows[i].inv;
			@(posedge clk);
			idle_code_wr <= 1'b0;
			repeat (3) send_frame(5'h01);
			chk_pops(rows[i].exp);
			$display("idle row %0d done", i);
		end
		// half-rate sink: the store fills and must delete a frame
		pace <= 2'h1;
		repeat (8) send_frame(5'h01);
		// a stalled sink stops reading, so no slip is in flight while counting
		pace <= 2'h2;
		repeat (8) @(posedge clk);
		chk({15'h0000, n_del > 0}, 16'h0001);
		chk({15'h0000, n_rep > 0}, 16'h0001);
		chk(slip_count_q, 16'(n_rep + n_del));
		chk({11'h000, slip_fnum_q}, 16'h0001);
		$display("slip test done");
		rst_n <= 1'b0;
		bypass <= 1'b1;
		oof <= 1'b0;
		inv_en <= 32'h0;
		pace <= 2'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		slip_hold = slip_count_q;
		run_sf(6, 12, 3, 5);
		chk(slip_count_q, slip_hold);
		chk({15'h0000, chg3}, 16'h0001);
		$display("sf signaling test done");
		rst_n <= 1'b0;
		fmt <= rxes_pkg::FMT_ESF;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		run_sf(3, 24, 2, 2);
		chk(slip_count_q, 16'h0000);
		chk({15'h0000, chg3}, 16'h0001);
		$display("esf signaling test done");
		stop_test();
	end
endmodule
